// >>> rtl/mux_addr_cmd.sv
// Overview of operation
// - Mode reg zero bit 9 enables two-cycle addressing
// - After mode reg two, termination off or selected
// - Second phase balls map to documented address bits
// - Data latency starts at second address phase
// - Row cycle starts at command edge
// - Refresh executes one edge after command
// - Refresh uses address or bank lines per variant
`timescale 1ns/100ps
`default_nettype none
module mux_addr_cmd
   import mux_addr_pkg::*;
#(
   parameter logic [7:0] MODE_LOAD_WAIT = MODE_WAIT_CYC
) (
   input  wire logic              I_SYS_CLK,
   input  wire logic              I_RESET_N,
   input  wire logic              I_CS_N,
   input  wire logic              I_WE_N,
   input  wire logic              I_REF_N,
   input  wire logic [ADDR_W-1:0] I_ADDR,
   input  wire logic [BANK_W-1:0] I_BANK,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic                   PREADY,
   output logic      [31:0]       PRDATA,
   output logic                   PSLVERR,
   output logic                   O_CMD_READ,
   output logic                   O_CMD_WRITE,
   output logic      [ADDR_W-1:0] O_ADDR,
   output logic      [BANK_W-1:0] O_BANK,
   output logic                   O_DATA_START,
   output logic                   O_DATA_DUE,
   output logic                   O_ROW_START,
   output logic                   O_REFRESH,
   output logic      [15:0]       O_REFRESH_BANKS,
   output logic                   O_ODT_EN,
   output logic                   O_MUX_MODE
);

   typedef struct packed {
      state_t              st;
      cmd_t                p1_cmd;
      logic [ADDR_W-1:0]   p1_addr;
      logic [BANK_W-1:0]   p1_bank;
      logic [MR_W-1:0]     mr0;
      logic [MR_W-1:0]     mr1;
      logic [MR_W-1:0]     mr2;
      logic                mr2_done;
      logic                odt_en;
      logic                mux;
      logic [7:0]          wait_cnt;
      logic [2:0]          init_stage;
      logic                x36;
      logic                mb_sel;
      logic [3:0]          lat;
      logic [3:0]          lat_cnt;
      logic                lat_busy;
      logic [ERR_W-1:0]    err;
      logic                ref_pend;
      logic [15:0]         ref_mask;
      logic                rd;
      logic                wr;
      logic [ADDR_W-1:0]   addr;
      logic [BANK_W-1:0]   bank;
      logic                dstart;
      logic                ddue;
      logic                rowstart;
      logic                refr;
      logic [15:0]         refbanks;
      logic                pready;
      logic [31:0]         prdata;
      logic                pslverr;
   } state_s_t;

   state_s_t s_q;
   state_s_t s_d;
   cmd_t              cmd;
   logic [ADDR_W-1:0] merged;

   assign cmd = decode_cmd(I_CS_N, I_WE_N, I_REF_N);

   addr_phase_merge u_merge (
      .i_phase1 (s_q.p1_addr),
      .i_phase2 (I_ADDR),
      .i_x36    (s_q.x36),
      .i_burst  (s_q.mr1[MR1_BL_LSB +: 2]),
      .o_addr   (merged)
   );

   always_comb begin
      logic              ex_go;
      cmd_t              ex_cmd;
      logic [ADDR_W-1:0] ex_addr;
      logic [BANK_W-1:0] ex_bank;
      logic [MR_W-1:0]   mr_data;
      ex_go   = 1'b0;
      ex_cmd  = CMD_NOP;
      ex_addr = '0;
      ex_bank = '0;
      mr_data = '0;
      s_d = s_q;
      s_d.rd       = 1'b0;
      s_d.wr       = 1'b0;
      s_d.dstart   = 1'b0;
      s_d.ddue     = 1'b0;
      s_d.rowstart = 1'b0;
      s_d.refr     = 1'b0;
      s_d.ref_pend = 1'b0;

      // APB: three-cycle access (one wait state) keeps pready a clean flop output
      s_d.pready  = PSEL && PENABLE && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.prdata  = '0;
      if (PSEL && PENABLE && !s_q.pready) begin
         if (PADDR == OFF_CTRL) begin
            s_d.prdata = {24'h00_0000, s_q.lat, 2'b00, s_q.mb_sel, s_q.x36};
         end else if (PADDR == OFF_STATUS) begin
            s_d.prdata = {25'h000_0000, s_q.init_stage, 1'b0,
                          s_q.mr2_done, s_q.odt_en, s_q.mux};
         end else if (PADDR == OFF_ERR) begin
            s_d.prdata = {27'h000_0000, s_q.err};
         end else if (PADDR == OFF_MR0) begin
            s_d.prdata = {14'h0000, s_q.mr0};
         end else if (PADDR == OFF_MR1) begin
            s_d.prdata = {14'h0000, s_q.mr1};
         end else if (PADDR == OFF_MR2) begin
            s_d.prdata = {14'h0000, s_q.mr2};
         end else begin
            s_d.pslverr = 1'b1;
         end
      end
      if (PSEL && PENABLE && s_q.pready && PWRITE) begin
         if (PADDR == OFF_CTRL) begin
            s_d.x36    = PWDATA[0];
            s_d.mb_sel = PWDATA[1];
            s_d.lat    = PWDATA[7:4];
         end else if (PADDR == OFF_ERR) begin
            // Clear first so a same-cycle event below still wins
            s_d.err = s_q.err & ~PWDATA[ERR_W-1:0];
         end
      end

      if (s_q.wait_cnt != 8'h00) begin
         s_d.wait_cnt = s_q.wait_cnt - 8'h01;
      end
      if (s_q.lat_busy) begin
         if (s_q.lat_cnt == 4'h0) begin
            s_d.ddue     = 1'b1;
            s_d.lat_busy = 1'b0;
         end else begin
            s_d.lat_cnt = s_q.lat_cnt - 4'h1;
         end
      end
      if (s_q.ref_pend) begin
         s_d.refr     = 1'b1;
         s_d.refbanks = s_q.ref_mask;
      end

      case (s_q.st)
         ST_IDLE: begin
            if (cmd == CMD_READ || cmd == CMD_WRITE || cmd == CMD_REF) begin
               s_d.rowstart = 1'b1;
            end
            if (cmd != CMD_NOP) begin
               if (!s_q.mux) begin
                  ex_go   = 1'b1;
                  ex_cmd  = cmd;
                  ex_addr = I_ADDR;
                  ex_bank = I_BANK;
               end else if (cmd == CMD_REF && !s_q.mb_sel) begin
                  // Bank only: no second phase, next command free
                  s_d.ref_pend = 1'b1;
                  s_d.ref_mask = 16'h0001 << I_BANK;
               end else begin
                  s_d.st      = ST_PHASE2;
                  s_d.p1_cmd  = cmd;
                  s_d.p1_addr = I_ADDR;
                  s_d.p1_bank = I_BANK;
               end
            end
         end
         ST_PHASE2: begin
            // Edge carries the second phase; a command here is dropped
            if (cmd != CMD_NOP) begin
               s_d.err[ERR_COLLIDE] = 1'b1;
            end
            ex_go   = 1'b1;
            ex_cmd  = s_q.p1_cmd;
            ex_addr = merged;
            ex_bank = s_q.p1_bank;
            s_d.st  = ST_IDLE;
         end
         default: s_d.st = ST_IDLE;
      endcase

      if (ex_go) begin
         case (ex_cmd)
            CMD_READ, CMD_WRITE: begin
               s_d.rd       = (ex_cmd == CMD_READ);
               s_d.wr       = (ex_cmd == CMD_WRITE);
               s_d.addr     = ex_addr;
               s_d.bank     = ex_bank;
               s_d.dstart   = 1'b1;
               s_d.lat_cnt  = s_q.lat;
               s_d.lat_busy = 1'b1;
            end
            CMD_REF: begin
               s_d.refr = 1'b1;
               if (s_q.mb_sel) begin
                  s_d.refbanks = ex_addr[15:0];
               end else begin
                  s_d.refbanks = 16'h0001 << ex_bank;
               end
            end
            CMD_MRS: begin
               mr_data = ex_addr[MR_W-1:0];
               if (s_q.mux && ex_bank[3:2] != 2'b00) begin
                  s_d.err[ERR_BA_HIGH] = 1'b1;
               end
               if (s_q.mux && s_q.wait_cnt != 8'h00) begin
                  s_d.err[ERR_WAIT] = 1'b1;
               end
               if (ex_bank[1:0] == 2'd0) begin
                  s_d.mr0 = mr_data;
                  s_d.mux = mr_data[MR0_MUX_BIT];
                  if (!s_q.mux && mr_data[MR0_MUX_BIT]) begin
                     s_d.wait_cnt   = MODE_LOAD_WAIT;
                     s_d.init_stage = 3'd1;
                  end
                  if (s_q.mux && !mr_data[MR0_MUX_BIT]) begin
                     s_d.err[ERR_MR0_LOW] = 1'b1;
                  end
                  if (s_q.mux && s_q.init_stage == 3'd1) begin
                     s_d.init_stage = 3'd2;
                  end
               end else if (ex_bank[1:0] == 2'd1) begin
                  s_d.mr1 = mr_data;
                  if (s_q.x36 && mr_data[MR1_BL_LSB +: 2] == BL_8) begin
                     s_d.err[ERR_BL8] = 1'b1;
                  end
                  if (s_q.mux && s_q.init_stage == 3'd2) begin
                     s_d.init_stage = 3'd3;
                  end
               end else if (ex_bank[1:0] == 2'd2) begin
                  s_d.mr2      = mr_data;
                  s_d.mr2_done = 1'b1;
                  s_d.odt_en   = |s_q.mr1[MR1_ODT_LSB +: MR1_ODT_W];
                  if (s_q.mux && s_q.init_stage == 3'd3) begin
                     s_d.init_stage = 3'd4;
                  end
               end
            end
            default: s_d.st = s_d.st;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESET_N) begin
         s_q          <= '0;
         s_q.st       <= ST_IDLE;
         s_q.p1_cmd   <= CMD_NOP;
         s_q.mr0      <= MR_RST;
         s_q.mr1      <= MR_RST;
         s_q.mr2      <= MR_RST;
         s_q.lat      <= LAT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign PREADY          = s_q.pready;
   assign PRDATA          = s_q.prdata;
   assign PSLVERR         = s_q.pslverr;
   assign O_CMD_READ      = s_q.rd;
   assign O_CMD_WRITE     = s_q.wr;
   assign O_ADDR          = s_q.addr;
   assign O_BANK          = s_q.bank;
   assign O_DATA_START    = s_q.dstart;
   assign O_DATA_DUE      = s_q.ddue;
   assign O_ROW_START     = s_q.rowstart;
   assign O_REFRESH       = s_q.refr;
   assign O_REFRESH_BANKS = s_q.refbanks;
   assign O_ODT_EN        = s_q.odt_en;
   assign O_MUX_MODE      = s_q.mux;

   AST_MUX_ENTER: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_IDLE && !s_q.mux && cmd == CMD_MRS
       && I_BANK[1:0] == 2'd0 && I_ADDR[MR0_MUX_BIT])
      |=> O_MUX_MODE && s_q.wait_cnt == MODE_LOAD_WAIT)
      else $error("Mode bit did not enter two-cycle mode");

   AST_DATA_AT_PHASE2: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_IDLE && s_q.mux
       && (cmd == CMD_READ || cmd == CMD_WRITE))
      |=> !O_DATA_START ##1 O_DATA_START)
      else $error("Data latency not started at second phase");

   AST_ROW_AT_CMD: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_IDLE && cmd != CMD_NOP && cmd != CMD_MRS)
      |=> O_ROW_START)
      else $error("Row cycle not started at command edge");

   AST_REF_NEXT_EDGE: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_IDLE && s_q.mux && cmd == CMD_REF)
      |=> !O_REFRESH ##1 O_REFRESH)
      else $error("Refresh not executed one edge after command");

   AST_BANK_REF_FREE: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_IDLE && s_q.mux && cmd == CMD_REF && !s_q.mb_sel)
      |=> s_q.st == ST_IDLE)
      else $error("Bank refresh blocked the next clock");

   AST_BANK_REF_ONEHOT: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_IDLE && s_q.mux && cmd == CMD_REF && !s_q.mb_sel)
      |=> ##1 O_REFRESH
          && O_REFRESH_BANKS == (16'h0001 << $past(I_BANK, 2)))
      else $error("Bank refresh mask not from bank lines");

   AST_ODT_AFTER_MR2: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      !s_q.mr2_done |-> !O_ODT_EN)
      else $error("Termination enabled before mode reg two");

   AST_COLLIDE_FLAG: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_PHASE2 && cmd != CMD_NOP)
      |=> s_q.err[ERR_COLLIDE] ##1 s_q.err[ERR_COLLIDE])
      else $error("Second-phase collision not flagged");

   AST_PHASE2_MAP: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_PHASE2 && s_q.p1_cmd == CMD_READ)
      |=> O_CMD_READ && O_ADDR[1] == $past(I_ADDR[3])
          && O_ADDR[15] == $past(I_ADDR[18]))
      else $error("Second-phase address mapping wrong");

   AST_BL8_X36: assert property (@(posedge I_SYS_CLK)
      disable iff (!I_RESET_N)
      (s_q.st == ST_PHASE2 && s_q.p1_cmd == CMD_MRS && s_q.x36
       && s_q.p1_bank[1:0] == 2'd1 && merged[MR1_BL_LSB +: 2] == BL_8)
      |=> s_q.err[ERR_BL8])
      else $error("Burst of eight on wide part not flagged");

endmodule
`default_nettype wire

// >>> rtl/mux_addr_pkg.sv
package mux_addr_pkg;

   localparam int ADDR_W = 20;
   localparam int BANK_W = 4;
   localparam int MR_W   = 18;
   localparam int ERR_W  = 5;

   // APB register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ERR    = 8'h08;
   localparam logic [7:0] OFF_MR0    = 8'h0C;
   localparam logic [7:0] OFF_MR1    = 8'h10;
   localparam logic [7:0] OFF_MR2    = 8'h14;

   // Mode register fields
   localparam int MR0_MUX_BIT  = 9;
   localparam int MR1_BL_LSB   = 3;
   localparam int MR1_ODT_LSB  = 0;
   localparam int MR1_ODT_W    = 3;
   localparam logic [1:0] BL_2 = 2'h0;
   localparam logic [1:0] BL_4 = 2'h1;
   localparam logic [1:0] BL_8 = 2'h2;

   // Sticky error bits
   localparam int ERR_COLLIDE = 0;
   localparam int ERR_WAIT    = 1;
   localparam int ERR_BL8     = 2;
   localparam int ERR_BA_HIGH = 3;
   localparam int ERR_MR0_LOW = 4;

   // Reset values and counts
   localparam logic [MR_W-1:0] MR_RST       = 18'h0_0000;
   localparam logic [3:0]      LAT_RST      = 4'h3;
   localparam logic [7:0]      MODE_WAIT_CYC = 8'h0C;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_MRS, CMD_READ, CMD_WRITE, CMD_REF
   } cmd_t;

   typedef enum logic {ST_IDLE, ST_PHASE2} state_t;

   // Pin encoding: cs_n, we_n, ref_n
   function automatic cmd_t decode_cmd(input logic cs_n,
                                       input logic we_n,
                                       input logic ref_n);
      cmd_t c;
      c = CMD_NOP;
      if (!cs_n) begin
         case ({we_n, ref_n})
            2'b00:   c = CMD_MRS;
            2'b11:   c = CMD_READ;
            2'b01:   c = CMD_WRITE;
            default: c = CMD_REF;
         endcase
      end
      return c;
   endfunction

endpackage

// >>> rtl/addr_phase_merge.sv
`timescale 1ns/100ps
`default_nettype none
module addr_phase_merge
   import mux_addr_pkg::*;
(
   input  wire logic [ADDR_W-1:0] i_phase1,
   input  wire logic [ADDR_W-1:0] i_phase2,
   input  wire logic              i_x36,
   input  wire logic [1:0]        i_burst,
   output logic      [ADDR_W-1:0] o_addr
);

   logic top_used;
   logic a19_used;

   // Top first-phase bit is don't care for x36 BL4 and x18 BL8
   assign top_used = i_x36 ? (i_burst == BL_2) : (i_burst != BL_8);
   // Ball 10 carries A19 only for x18 burst of two
   assign a19_used = !i_x36 && (i_burst == BL_2);

   always_comb begin
      o_addr = '0;
      o_addr[0]  = i_phase1[0];
      o_addr[3]  = i_phase1[3];
      o_addr[4]  = i_phase1[4];
      o_addr[5]  = i_phase1[5];
      o_addr[8]  = i_phase1[8];
      o_addr[9]  = i_phase1[9];
      o_addr[10] = i_phase1[10];
      o_addr[13] = i_phase1[13];
      o_addr[14] = i_phase1[14];
      o_addr[17] = i_phase1[17];
      o_addr[18] = top_used & i_phase1[18];
      o_addr[1]  = i_phase2[3];
      o_addr[2]  = i_phase2[4];
      o_addr[6]  = i_phase2[8];
      o_addr[7]  = i_phase2[9];
      o_addr[11] = i_phase2[13];
      o_addr[12] = i_phase2[14];
      o_addr[16] = i_phase2[17];
      o_addr[15] = i_phase2[18];
      o_addr[19] = a19_used & i_phase2[10];
   end

endmodule
`default_nettype wire

// >>> tb/mux_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module mux_ctrl_model
   import mux_addr_pkg::*;
(
   input  wire logic              i_clk,
   output logic                   o_cs_n,
   output logic                   o_we_n,
   output logic                   o_ref_n,
   output logic      [ADDR_W-1:0] o_addr,
   output logic      [BANK_W-1:0] o_bank
);
   initial begin
      o_cs_n  = 1'b1;
      o_we_n  = 1'b1;
      o_ref_n = 1'b1;
      o_addr  = 20'h0_0000;
      o_bank  = 4'h0;
   end

   // Op is {we_n, ref_n}; two sends a second address phase
   task automatic send(input logic [1:0] op, input logic [ADDR_W-1:0] a1,
                       input logic [ADDR_W-1:0] a2,
                       input logic [BANK_W-1:0] bk, input bit two,
                       input bit clash);
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      {o_we_n, o_ref_n} <= op;
      o_addr <= a1;
      o_bank <= (op == 2'b00) ? {2'b00, bk[1:0]} : bk;
      // Bank refresh skips this, so the next command may follow
      if (two) begin
         @(posedge i_clk);
         o_cs_n <= !clash;
         o_addr <= a2;
      end
   endtask

   // Released lines flip so stale values never look valid
   task automatic idle();
      @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_addr <= ~o_addr;
      o_bank <= ~o_bank;
   endtask
endmodule
`default_nettype wire

// >>> tb/multiplexed_address_mode_bench.sv
`timescale 1ns/100ps
`default_nettype none
module multiplexed_address_mode_bench
   import mux_addr_pkg::*;
;
   localparam int WAIT_CYC = 2;
   logic clk = 1'b0, rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, cs_n, we_n, ref_n, c_rd, c_wr, d_st, d_due;
   logic row, rfs, odt, mux;
   logic [ADDR_W-1:0] addr, o_addr;
   logic [BANK_W-1:0] bank, o_bank;
   logic [15:0] rmask;
   int n_mismatch = 0, n_checks = 0;

   always #2.5 clk = ~clk;

   mux_ctrl_model ctl_u (.i_clk(clk), .o_cs_n(cs_n), .o_we_n(we_n),
      .o_ref_n(ref_n), .o_addr(addr), .o_bank(bank));

   mux_addr_cmd #(.MODE_LOAD_WAIT(8'h02)) dut_u (.I_SYS_CLK(clk),
      .I_RESET_N(rst_n), .I_CS_N(cs_n), .I_WE_N(we_n), .I_REF_N(ref_n),
      .I_ADDR(addr), .I_BANK(bank), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .O_CMD_READ(c_rd),
      .O_CMD_WRITE(c_wr), .O_ADDR(o_addr), .O_BANK(o_bank),
      .O_DATA_START(d_st), .O_DATA_DUE(d_due), .O_ROW_START(row),
      .O_REFRESH(rfs), .O_REFRESH_BANKS(rmask), .O_ODT_EN(odt),
      .O_MUX_MODE(mux));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h0000_0001, "no pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input string m);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x, m);
   endtask

   function automatic logic [19:0] merge(input logic [19:0] a,
                                         input logic [19:0] b);
      logic [19:0] r;
      r = a & 20'h6_6739;
      {r[1], r[2], r[6], r[7]} = {b[3], b[4], b[8], b[9]};
      {r[11], r[12], r[16], r[15], r[19]} =
         {b[13], b[14], b[17], b[18], b[10]};
      return r;
   endfunction

   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd(OFF_CTRL, 32'h0000_0030, "ctrl reset");
      rd(OFF_STATUS, 32'h0000_0000, "status reset");
      rd(OFF_MR0, 32'h0000_0000, "mr0 reset");
      wr(OFF_STATUS, 32'hFFFF_FFFF);
      rd(OFF_STATUS, 32'h0000_0000, "status is ro");
      apb(1'b0, 8'h40, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000, "unmapped data");
      chk(32'(e), 32'h0000_0001, "unmapped error");
      $display("test reset done");
   endtask

   task automatic t_init();
      ctl_u.send(2'b00, 20'h0_0200, 20'h0_0000, 4'h0, 0, 0);
      ctl_u.idle();
      @(negedge clk) chk(32'(mux), 32'h0000_0001, "mux mode");
      repeat (WAIT_CYC + 1) @(posedge clk);
      ctl_u.send(2'b00, 20'h0_0200, 20'h0_0000, 4'h0, 1, 0);
      ctl_u.send(2'b00, 20'h0_0001, 20'h0_0000, 4'h1, 1, 0);
      ctl_u.idle();
      @(negedge clk) chk(32'(odt), 32'h0000_0000, "odt early");
      ctl_u.send(2'b00, 20'h0_0000, 20'h0_0000, 4'h2, 1, 0);
      ctl_u.idle();
      repeat (2) @(negedge clk);
      chk(32'(odt), 32'h0000_0001, "odt on");
      rd(OFF_STATUS, 32'h0000_0047, "status init");
      rd(OFF_MR0, 32'h0000_0200, "mr0 value");
      rd(OFF_MR1, 32'h0000_0001, "mr1 value");
      rd(OFF_ERR, 32'h0000_0000, "no errors");
      $display("test init done");
   endtask

   task automatic t_read();
      ctl_u.send(2'b11, 20'h5_A5C3, 20'hA_3C96, 4'h5, 1, 0);
      @(negedge clk) chk(32'(row), 32'h0000_0001, "row start");
      ctl_u.idle();
      @(negedge clk);
      chk({c_rd, d_st, o_bank}, 32'h0000_0035, "read exec");
      chk(32'(o_addr), 32'(merge(20'h5_A5C3, 20'hA_3C96)), "addr");
      repeat (4) @(negedge clk);
      chk(32'(d_due), 32'h0000_0001, "latency");
      $display("test read done");
   endtask

   task automatic t_refresh();
      wr(OFF_CTRL, 32'h0000_0032);
      ctl_u.send(2'b10, 20'hF_0F0F, 20'h3_C3C3, 4'hF, 1, 0);
      ctl_u.idle();
      @(negedge clk) chk(32'(rfs), 32'h0000_0001, "mb refresh");
      chk(32'(rmask), 32'(16'(merge(20'hF_0F0F, 20'h3_C3C3))), "mask");
      wr(OFF_CTRL, 32'h0000_0030);
      ctl_u.send(2'b10, 20'h0_0000, 20'h0_0000, 4'h3, 0, 0);
      ctl_u.send(2'b11, 20'h0_0001, 20'h0_0000, 4'h0, 1, 0);
      @(negedge clk) chk({rfs, row}, 32'h0000_0003, "bank ref");
      chk(32'(rmask), 32'h0000_0008, "bank mask");
      ctl_u.idle();
      @(negedge clk) chk(32'(c_rd), 32'h0000_0001, "read after");
      rd(OFF_ERR, 32'h0000_0000, "refresh legal");
      $display("test refresh done");
   endtask

   task automatic t_clash();
      int np;
      np = 0;
      ctl_u.send(2'b01, 20'h0_1234, 20'h0_4321, 4'h2, 1, 1);
      ctl_u.idle();
      repeat (6) @(negedge clk) np += int'(c_wr);
      chk(np, 32'h0000_0001, "one write");
      rd(OFF_ERR, 32'h0000_0001, "clash flag");
      wr(OFF_ERR, 32'h0000_001F);
      rd(OFF_ERR, 32'h0000_0000, "w1c");
      $display("test clash done");
   endtask

   // Deliberate rule breaks on the far side, each must leave a flag
   task automatic t_errs();
      wr(OFF_CTRL, 32'h0000_0031);
      ctl_u.send(2'b00, 20'h0_0010, 20'h0_0000, 4'h1, 1, 0);
      ctl_u.send(2'b00, 20'h0_0000, 20'h0_0000, 4'h0, 1, 0);
      ctl_u.send(2'b00, 20'h0_0200, 20'h0_0000, 4'h0, 0, 0);
      ctl_u.send(2'b00, 20'h0_0200, 20'h0_0000, 4'h0, 1, 0);
      ctl_u.idle();
      rd(OFF_ERR, 32'h0000_0016, "error flags");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFF_STATUS, 32'h0000_0000, "status after reset");
      rd(OFF_CTRL, 32'h0000_0030, "ctrl after reset");
      $display("test errors done");
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_init();
      t_read();
      t_refresh();
      t_clash();
      t_errs();
      wrap_up();
   end

   // Whole run is well under 1000 cycles
   initial begin
      #20000;
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
